// *** pkg/swea_pkg.sv ***
// constants for the management interrupt and wake event aggregator
package swea_pkg;

	// default source counts
	localparam int SWEA_EDGE_SRCS = 21;
	localparam int SWEA_PERIPH_SRCS = 6;
	localparam int SWEA_MAX_EDGE_SRCS = 32;

	// fixed wake sources besides the edge pins
	localparam int SWEA_FIXED_WAKE = 5;
	localparam int SWEA_WK_RING_ONE = 0;
	localparam int SWEA_WK_RING_TWO = 1;
	localparam int SWEA_WK_KBD = 2;
	localparam int SWEA_WK_MOUSE = 3;
	localparam int SWEA_WK_IR = 4;

	// fixed pins in the synchroniser vector
	localparam int SWEA_FIXED_PINS = 4;

	// smi_enable_two field positions
	localparam int SWEA_EN2_PIN_ROUTE = 7;
	localparam int SWEA_EN2_SERIRQ_ROUTE = 6;
	localparam int SWEA_EN2_WAKE_ROUTE = 5;

	// pin gpio control register fields
	localparam int SWEA_CTL_POLARITY = 1;
	localparam int SWEA_CTL_PUSH_PULL = 7;

	// reset values of the output pin drivers (inactive, released)
	localparam logic SWEA_PIN_O_RST = 1'h1;
	localparam logic SWEA_PIN_OE_N_RST = 1'h1;

	// synchroniser stage reset value
	localparam logic SWEA_SYNC_RST = 1'h0;

	// reset value of every status bit
	localparam logic SWEA_STS_RST = 1'h0;

	// pin driver mode
	typedef enum logic [1:0] {
		SWEA_DRV_OD_LOW,
		SWEA_DRV_OD_HIGH,
		SWEA_DRV_PP_LOW,
		SWEA_DRV_PP_HIGH
	} swea_drv_t;

endpackage

// *** hdl/swea_aggregator.sv ***
// management interrupt and wake event aggregator
`timescale 1ns/1ps

// Function
// - group interrupt is OR over all five register sets of status AND enable
// - group interrupt reaches its own pin only when enable two bit 7 set
// - enable two bit 6 places group interrupt in serial slot IRQ2
// - enable two bit 5 feeds group interrupt into wake logic
// - interrupt pin polarity and open-drain/push-pull programmable; reset active-low open-drain
// - gpio and fan sources latch on polarity-selected edge, rising when not inverted
// - dual-edge gpio sets its interrupt status on both edges
// - gpio interrupt status clears on write one; zero leaves it
// - gpio and fan latched status ANDed with enable for the interrupt
// - peripheral events ANDed live with enables, no latching
// - peripheral status follows its source; write one does not clear it
// - infrared event status clears when status register two is read
// - wake status set by ring, infrared, keyboard, mouse, gpio and fan events
// - wake pin polarity and buffer type programmable; reset active-low open-drain
// - wake pin never asserts without global enable; else any enabled status asserts
// - wake status bits set regardless of global wake enable
// - gpio wake status on polarity edge or both edges; write one clears
// - wake status and enable include fan tachometer event bits
// - smi_to_wake_status set by active group interrupt with bit 5; write one clears
// - smi_to_wake enable plus status drives the wake pin active when global wake enable is set
module swea_aggregator
	import swea_pkg::*;
#(
	parameter int EDGE_SRCS = SWEA_EDGE_SRCS,
	parameter int PERIPH_SRCS = SWEA_PERIPH_SRCS
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,

	// peripheral block events, live levels
	input wire logic [PERIPH_SRCS-1:0] periph_event,
	input wire logic [PERIPH_SRCS-1:0] periph_smi_enable,
	input wire logic infrared_frame_valid,
	input wire logic infrared_smi_enable,
	input wire logic smi_status_two_read,
	output logic infrared_event,

	// gpio and fan tachometer edge sources
	input wire logic [EDGE_SRCS-1:0] edge_src_pin,
	input wire logic [EDGE_SRCS-1:0] edge_src_polarity,
	input wire logic [EDGE_SRCS-1:0] dual_edge_trigger,
	input wire logic [EDGE_SRCS-1:0] edge_smi_enable,
	input wire logic [EDGE_SRCS-1:0] edge_smi_clear,
	output logic [EDGE_SRCS-1:0] edge_smi_status,

	// other wake sources, active low pins
	input wire logic ring_indicator_one_n,
	input wire logic ring_indicator_two_n,
	input wire logic kbd_data_n,
	input wire logic mouse_data_n,

	// wake status and enables
	input wire logic [EDGE_SRCS-1:0] edge_wake_enable,
	input wire logic [EDGE_SRCS-1:0] edge_wake_clear,
	output logic [EDGE_SRCS-1:0] edge_wake_status,
	input wire logic [SWEA_FIXED_WAKE-1:0] fixed_wake_enable,
	input wire logic [SWEA_FIXED_WAKE-1:0] fixed_wake_clear,
	output logic [SWEA_FIXED_WAKE-1:0] fixed_wake_status,
	input wire logic global_wake_enable,
	output logic wake_summary_status,

	// group interrupt into the wake logic
	input wire logic smi_to_wake_enable,
	input wire logic smi_to_wake_clear,
	output logic smi_to_wake_status,

	// routing and pin control
	input wire logic [7:0] smi_enable_two,
	input wire logic [7:0] smi_pin_gpio_control,
	input wire logic [7:0] wake_pin_gpio_control,

	// outputs toward the chipset
	output logic group_smi_internal,
	output logic serirq_irq2_req,
	output logic group_smi_pin_o,
	output logic group_smi_pin_oe_n,
	output logic wake_event_pin_o,
	output logic wake_event_pin_oe_n
);

	localparam int SYNC_W = EDGE_SRCS + SWEA_FIXED_PINS;

	// refuse source counts the logic cannot serve
	generate
		if (EDGE_SRCS < 1 || EDGE_SRCS > SWEA_MAX_EDGE_SRCS)
		begin : g_bad_edge
			$error("edge source count out of range");
		end
		if (PERIPH_SRCS < 1)
		begin : g_bad_periph
			$error("peripheral source count must be at least one");
		end
		if (SWEA_FIXED_PINS != 4)
		begin : g_bad_pins
			$error("four fixed wake pins feed the synchroniser");
		end
		if (SWEA_WK_IR >= SWEA_FIXED_WAKE)
		begin : g_bad_fixed
			$error("fixed wake bit positions exceed the vector");
		end
		if (SWEA_CTL_PUSH_PULL > 7 || SWEA_CTL_POLARITY > 7)
		begin : g_bad_ctl
			$error("pin control fields lie outside the byte");
		end
		if (SWEA_EN2_PIN_ROUTE > 7 || SWEA_EN2_SERIRQ_ROUTE > 7
			|| SWEA_EN2_WAKE_ROUTE > 7)
		begin : g_bad_route
			$error("route enable fields lie outside the byte");
		end
	endgenerate

	// synchroniser and edge history
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] meta_d;
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] sync_d;
	logic [SYNC_W-1:0] prev_q;
	logic [SYNC_W-1:0] prev_d;

	// history warm-up and qualified edges
	logic [2:0] warm_q;
	logic [2:0] warm_d;
	logic hist_ok;
	logic [SYNC_W-1:0] pin_rise;
	logic [SYNC_W-1:0] pin_fall;

	// latched status
	logic [EDGE_SRCS-1:0] edge_smi_q;
	logic [EDGE_SRCS-1:0] edge_smi_d;
	logic [EDGE_SRCS-1:0] edge_wake_q;
	logic [EDGE_SRCS-1:0] edge_wake_d;
	logic [SWEA_FIXED_WAKE-1:0] fixed_wake_q;
	logic [SWEA_FIXED_WAKE-1:0] fixed_wake_d;
	logic ir_event_q;
	logic ir_event_d;
	logic smi_wake_q;
	logic smi_wake_d;

	// output pin drivers
	logic smi_o_q;
	logic smi_o_d;
	logic smi_oe_n_q;
	logic smi_oe_n_d;
	logic wake_o_q;
	logic wake_o_d;
	logic wake_oe_n_q;
	logic wake_oe_n_d;

	// combinational terms
	logic [EDGE_SRCS-1:0] src_edge;
	logic [SWEA_FIXED_WAKE-1:0] fixed_event;
	logic group_smi;
	logic smi_pin_active;
	logic wake_active;
	logic wake_pending;

	// raw pins gathered for the synchroniser
	logic [SYNC_W-1:0] raw_pins;
	assign raw_pins = {mouse_data_n, kbd_data_n, ring_indicator_two_n,
		ring_indicator_one_n, edge_src_pin};

	// two-flop synchroniser plus one history stage
	always_comb
	begin
		meta_d = raw_pins;
		sync_d = meta_q;
		prev_d = sync_q;
		warm_d = {warm_q[1:0], 1'h1};
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= {SYNC_W{SWEA_SYNC_RST}};
			sync_q <= {SYNC_W{SWEA_SYNC_RST}};
			prev_q <= {SYNC_W{SWEA_SYNC_RST}};
			warm_q <= 3'h0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			warm_q <= warm_d;
		end
	end

	// edges count only once all three stages hold sampled pins,
	// so a pin already high at reset release gives no false edge
	always_comb
	begin
		hist_ok = warm_q[2];
		pin_rise = sync_q & ~prev_q & {SYNC_W{hist_ok}};
		pin_fall = ~sync_q & prev_q & {SYNC_W{hist_ok}};
	end

	// per-source edge select: polarity edge or either edge
	genvar gi;
	generate
		for (gi = 0; gi < EDGE_SRCS; gi++)
		begin : g_edge
			logic rise;
			logic fall;
			assign rise = pin_rise[gi];
			assign fall = pin_fall[gi];
			assign src_edge[gi] = dual_edge_trigger[gi] ? (rise | fall) :
				(edge_src_polarity[gi] ? fall : rise);
		end
	endgenerate

	// fixed wake events: falling edges of active-low pins, ir frames
	always_comb
	begin
		fixed_event = '0;
		fixed_event[SWEA_WK_RING_ONE] = pin_fall[EDGE_SRCS];
		fixed_event[SWEA_WK_RING_TWO] = pin_fall[EDGE_SRCS+1];
		fixed_event[SWEA_WK_KBD] = pin_fall[EDGE_SRCS+2];
		fixed_event[SWEA_WK_MOUSE] = pin_fall[EDGE_SRCS+3];
		fixed_event[SWEA_WK_IR] = infrared_frame_valid;
	end

	// group interrupt from all five register sets
	always_comb
	begin
		group_smi = (|(periph_event & periph_smi_enable))
			| (ir_event_q & infrared_smi_enable)
			| (|(edge_smi_q & edge_smi_enable));
	end

	// status next values; a new event beats a clear in the same cycle
	always_comb
	begin
		edge_smi_d = (edge_smi_q & ~edge_smi_clear) | src_edge;
		edge_wake_d = (edge_wake_q & ~edge_wake_clear) | src_edge;
		fixed_wake_d = (fixed_wake_q & ~fixed_wake_clear) | fixed_event;
		ir_event_d = (ir_event_q & ~smi_status_two_read)
			| infrared_frame_valid;
		smi_wake_d = (smi_wake_q & ~smi_to_wake_clear)
			| (group_smi & smi_enable_two[SWEA_EN2_WAKE_ROUTE]);
	end

	// status registers, set regardless of global wake enable
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			edge_smi_q <= {EDGE_SRCS{SWEA_STS_RST}};
			edge_wake_q <= {EDGE_SRCS{SWEA_STS_RST}};
			fixed_wake_q <= {SWEA_FIXED_WAKE{SWEA_STS_RST}};
			ir_event_q <= SWEA_STS_RST;
			smi_wake_q <= SWEA_STS_RST;
		end
		else
		begin
			edge_smi_q <= edge_smi_d;
			edge_wake_q <= edge_wake_d;
			fixed_wake_q <= fixed_wake_d;
			ir_event_q <= ir_event_d;
			smi_wake_q <= smi_wake_d;
		end
	end

	// wake pending: any status with its enable, incl. the smi feed
	always_comb
	begin
		wake_pending = (|(edge_wake_q & edge_wake_enable))
			| (|(fixed_wake_q & fixed_wake_enable))
			| (smi_wake_q & smi_to_wake_enable);
		wake_active = global_wake_enable & wake_pending;
		smi_pin_active = group_smi & smi_enable_two[SWEA_EN2_PIN_ROUTE];
	end

	// maps active level, polarity and buffer type onto pin drive
	function automatic logic [1:0] pin_drive(input logic active,
		input logic [7:0] ctl);
		swea_drv_t mode;
		logic level;
		logic [1:0] res;
		mode = swea_drv_t'({ctl[SWEA_CTL_PUSH_PULL], ctl[SWEA_CTL_POLARITY]});
		level = ctl[SWEA_CTL_POLARITY] ? active : ~active;
		res = {SWEA_PIN_O_RST, SWEA_PIN_OE_N_RST};
		unique case (mode)
			SWEA_DRV_OD_LOW, SWEA_DRV_OD_HIGH:
			begin
				res = {1'h0, level}; // drive low only, else release
			end
			SWEA_DRV_PP_LOW, SWEA_DRV_PP_HIGH:
			begin
				res = {level, 1'h0};
			end
		endcase
		return res;
	endfunction

	// output pin drive next values
	always_comb
	begin
		{smi_o_d, smi_oe_n_d} =
			pin_drive(smi_pin_active, smi_pin_gpio_control);
		{wake_o_d, wake_oe_n_d} =
			pin_drive(wake_active, wake_pin_gpio_control);
	end

	// output pin drive registers, released and inactive at reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smi_o_q <= SWEA_PIN_O_RST;
			smi_oe_n_q <= SWEA_PIN_OE_N_RST;
			wake_o_q <= SWEA_PIN_O_RST;
			wake_oe_n_q <= SWEA_PIN_OE_N_RST;
		end
		else
		begin
			smi_o_q <= smi_o_d;
			smi_oe_n_q <= smi_oe_n_d;
			wake_o_q <= wake_o_d;
			wake_oe_n_q <= wake_oe_n_d;
		end
	end

	// status outputs
	assign edge_smi_status = edge_smi_q;
	assign edge_wake_status = edge_wake_q;
	assign fixed_wake_status = fixed_wake_q;
	assign infrared_event = ir_event_q;
	assign smi_to_wake_status = smi_wake_q;
	assign wake_summary_status = wake_pending;

	// group interrupt and its routes
	assign group_smi_internal = group_smi;
	assign serirq_irq2_req =
		group_smi & smi_enable_two[SWEA_EN2_SERIRQ_ROUTE];
	assign group_smi_pin_o = smi_o_q;
	assign group_smi_pin_oe_n = smi_oe_n_q;
	assign wake_event_pin_o = wake_o_q;
	assign wake_event_pin_oe_n = wake_oe_n_q;

endmodule

// *** tb/swea_props.sv ***
// assertions on the aggregator ports
`timescale 1ns/1ps
module swea_props
	import swea_pkg::*;
#(
	parameter int EDGE_SRCS = SWEA_EDGE_SRCS,
	parameter int PERIPH_SRCS = SWEA_PERIPH_SRCS
)
(
	// clock, reset and sources
	input logic ref_clk, rst_n,
	input logic [PERIPH_SRCS-1:0] periph_event, periph_smi_enable,
	input logic infrared_frame_valid, infrared_smi_enable,
	input logic smi_status_two_read, infrared_event,
	input logic [EDGE_SRCS-1:0] edge_src_pin, edge_src_polarity,
	input logic [EDGE_SRCS-1:0] dual_edge_trigger, edge_smi_enable,
	input logic [EDGE_SRCS-1:0] edge_smi_status, edge_wake_enable,
	input logic [EDGE_SRCS-1:0] edge_wake_status,
	input logic [SWEA_FIXED_WAKE-1:0] fixed_wake_enable, fixed_wake_status,
	// wake, routing and pins
	input logic global_wake_enable, wake_summary_status,
	input logic smi_to_wake_enable, smi_to_wake_status,
	input logic [7:0] smi_enable_two, smi_pin_gpio_control,
	input logic [7:0] wake_pin_gpio_control,
	input logic group_smi_internal, serirq_irq2_req,
	input logic group_smi_pin_o, group_smi_pin_oe_n,
	input logic wake_event_pin_o, wake_event_pin_oe_n
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// expected {o, oe_n} of each pin from its cause and control
	logic s_lvl, w_lvl;
	logic [1:0] s_drv, w_drv;
	assign s_lvl = (group_smi_internal & smi_enable_two[7])
		^ ~smi_pin_gpio_control[1];
	assign w_lvl = (global_wake_enable & wake_summary_status)
		^ ~wake_pin_gpio_control[1];
	assign s_drv = smi_pin_gpio_control[7] ? {s_lvl, 1'h0} : {1'h0, s_lvl};
	assign w_drv = wake_pin_gpio_control[7] ? {w_lvl, 1'h0} : {1'h0, w_lvl};

	// active edge on the first edge source
	sequence s_act0;
		$changed(edge_src_pin[0]) && (dual_edge_trigger[0]
			|| edge_src_pin[0] != edge_src_polarity[0]);
	endsequence

	property p_group;
		group_smi_internal == (|(periph_event & periph_smi_enable)
			| |(edge_smi_status & edge_smi_enable)
			| (infrared_event & infrared_smi_enable));
	endproperty
	property p_irq2;
		serirq_irq2_req == (group_smi_internal & smi_enable_two[6]);
	endproperty
	property p_smi_pin;
		1 |=> {group_smi_pin_o, group_smi_pin_oe_n} == $past(s_drv);
	endproperty
	property p_wake_pin;
		1 |=> {wake_event_pin_o, wake_event_pin_oe_n} == $past(w_drv);
	endproperty
	property p_summary;
		wake_summary_status == (|(edge_wake_status & edge_wake_enable)
			| |(fixed_wake_status & fixed_wake_enable)
			| (smi_to_wake_status & smi_to_wake_enable));
	endproperty
	property p_ir_clear;
		infrared_event && smi_status_two_read && !infrared_frame_valid
			|=> !infrared_event;
	endproperty
	property p_s2w;
		group_smi_internal && smi_enable_two[5] |=> smi_to_wake_status;
	endproperty
	property p_edge;
		s_act0 |-> ##[1:5] edge_smi_status[0] && edge_wake_status[0];
	endproperty

	a_group: assert property (p_group) else $error("group wrong");
	a_irq2: assert property (p_irq2) else $error("irq2 wrong");
	a_smi_pin: assert property (p_smi_pin) else $error("smi pin");
	a_wake_pin: assert property (p_wake_pin) else $error("wake pin");
	a_summary: assert property (p_summary) else $error("summary");
	a_ir_clear: assert property (p_ir_clear) else $error("ir clear");
	a_s2w: assert property (p_s2w) else $error("smi to wake");
	a_edge: assert property (p_edge) else $error("edge");
endmodule

bind swea_aggregator swea_props #(.EDGE_SRCS(EDGE_SRCS),
	.PERIPH_SRCS(PERIPH_SRCS)) i_props (.*);

// *** tb/swea_host.sv ***
// chipset side: pulled-up board wires of the two event pins
`timescale 1ns/1ps
module swea_host
(
	// pin drivers of the block
	input logic group_smi_pin_o, group_smi_pin_oe_n,
	input logic wake_event_pin_o, wake_event_pin_oe_n,
	// levels the chipset sees
	output logic smi_wire, wake_wire
);
	// a released pin reads at the pull-up level
	assign smi_wire = group_smi_pin_oe_n ? 1'h1 : group_smi_pin_o;
	assign wake_wire = wake_event_pin_oe_n ? 1'h1 : wake_event_pin_o;
endmodule

// *** tb/swea_aggregator_tb.sv ***
// self-checking bench for the aggregator
`timescale 1ns/1ps
module swea_aggregator_tb
	import swea_pkg::*;
;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] rng = 32'h34;
	logic ref_clk, rst_n, infrared_frame_valid, infrared_smi_enable;
	logic smi_status_two_read, infrared_event, global_wake_enable;
	logic ring_indicator_one_n, ring_indicator_two_n, kbd_data_n;
	logic mouse_data_n, wake_summary_status, smi_to_wake_enable;
	logic smi_to_wake_clear, smi_to_wake_status, group_smi_internal;
	logic serirq_irq2_req, group_smi_pin_o, group_smi_pin_oe_n;
	logic wake_event_pin_o, wake_event_pin_oe_n, smi_wire, wake_wire;
	logic [5:0] periph_event, periph_smi_enable;
	logic [20:0] edge_src_pin, edge_src_polarity, dual_edge_trigger;
	logic [20:0] edge_smi_enable, edge_smi_clear, edge_smi_status;
	logic [20:0] edge_wake_enable, edge_wake_clear, edge_wake_status;
	logic [4:0] fixed_wake_enable, fixed_wake_clear, fixed_wake_status;
	logic [7:0] smi_enable_two, smi_pin_gpio_control, wake_pin_gpio_control;

	swea_aggregator i_dut (.*);
	swea_host i_host (.*);

	// 100 MHz clock
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	// xorshift source of random stimulus
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// board level of a pin: active xor inverted polarity
	function automatic logic lvl(input logic act, input logic [7:0] ctl);
		return act ^ ~ctl[1];
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// cut a hang short
	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end

	// main sequence
	initial
	begin
		int k;
		logic [7:0] c;
		logic e;
		rst_n = 1'h0;
		{periph_event, periph_smi_enable, infrared_frame_valid,
			infrared_smi_enable, smi_status_two_read, edge_src_pin,
			edge_src_polarity, dual_edge_trigger, edge_smi_enable,
			edge_smi_clear, edge_wake_enable, edge_wake_clear,
			fixed_wake_enable, fixed_wake_clear, global_wake_enable,
			smi_to_wake_enable, smi_to_wake_clear, smi_enable_two,
			smi_pin_gpio_control, wake_pin_gpio_control} = '0;
		{ring_indicator_one_n, ring_indicator_two_n, kbd_data_n,
			mouse_data_n} = 4'hF;
		tick(20);
		check({group_smi_pin_o, group_smi_pin_oe_n, wake_event_pin_o,
			wake_event_pin_oe_n}, 4'hF, "pins in reset");
		rst_n = 1'h1;
		// random sources and routing
		repeat (20)
		begin
			periph_event = 6'(rnd());
			periph_smi_enable = 6'(rnd());
			smi_enable_two = 8'(rnd());
			e = |(periph_event & periph_smi_enable);
			tick(1);
			check(group_smi_internal, e, "group");
			check(serirq_irq2_req, e & smi_enable_two[6], "irq2");
		end
		// ring, keyboard and mouse edges with wake globally off
		{ring_indicator_one_n, ring_indicator_two_n, kbd_data_n,
			mouse_data_n} = 4'h0;
		tick(6);
		check(fixed_wake_status, 5'h0F, "fixed wake");
		fixed_wake_enable = 5'h01;
		// both pins over every polarity and buffer setting
		for (k = 0; k < 4; k++)
		begin
			c = {k[1], 5'h0, k[0], 1'h0};
			smi_pin_gpio_control = c;
			wake_pin_gpio_control = c;
			for (int a = 0; a < 2; a++)
			begin
				periph_event = {6{a[0]}};
				periph_smi_enable = 6'h3F;
				smi_enable_two = 8'h80;
				global_wake_enable = a[0];
				e = lvl(a[0], c);
				tick(2);
				check({smi_wire, group_smi_pin_oe_n}, {e, ~c[7] & e},
					"smi pin");
				check({wake_wire, wake_event_pin_oe_n}, {e, ~c[7] & e},
					"wake pin");
			end
		end
		// every pending fixed wake status cleared by write-one
		check(wake_summary_status, 1'h1, "summary pending");
		fixed_wake_clear = 5'h1E;
		tick(1);
		check(wake_summary_status, 1'h1, "summary held");
		fixed_wake_clear = 5'h1F;
		tick(1);
		fixed_wake_clear = 5'h00;
		tick(1);
		check(wake_summary_status, 1'h0, "summary");
		// gpio edges by polarity and dual-edge choice
		periph_event = 6'h00;
		edge_smi_enable = '1;
		edge_wake_enable = '1;
		for (int n = 0; n < 12; n++)
		begin
			// first rounds: pin 0 rising, then pin 0 on either edge
			k = (n < 2) ? 0 : int'(rnd() % 21);
			edge_src_polarity[k] = (n < 2) ? 1'h0 : 1'(rnd());
			dual_edge_trigger[k] = (n == 1) ? 1'h1 : 1'(rnd() >> 3);
			tick(6);
			edge_smi_clear = '1;
			edge_wake_clear = '1;
			tick(1);
			edge_smi_clear = '0;
			edge_wake_clear = '0;
			edge_src_pin[k] = ~edge_src_pin[k];
			e = dual_edge_trigger[k] | (edge_src_pin[k] ^ edge_src_polarity[k]);
			tick(6);
			check(edge_smi_status[k], e, "edge smi");
			check(edge_wake_status[k], e, "edge wake");
			check(group_smi_internal, e, "edge group");
		end
		// edge and write-one clear in the same cycle: the edge wins
		dual_edge_trigger[0] = 1'h1;
		edge_src_pin[0] = ~edge_src_pin[0];
		tick(2);
		edge_smi_clear[0] = 1'h1;
		edge_wake_clear[0] = 1'h1;
		tick(1);
		edge_smi_clear[0] = 1'h0;
		edge_wake_clear[0] = 1'h0;
		check({edge_smi_status[0], edge_wake_status[0]}, 2'h3,
			"set wins");
		edge_smi_enable = '0;
		edge_wake_enable = '0;
		// infrared frame latch, read clear, frame wins over read
		infrared_smi_enable = 1'h1;
		infrared_frame_valid = 1'h1;
		tick(1);
		infrared_frame_valid = 1'h0;
		tick(1);
		check({infrared_event, fixed_wake_status[SWEA_WK_IR],
			group_smi_internal}, 3'h7, "ir set");
		smi_status_two_read = 1'h1;
		infrared_frame_valid = 1'h1;
		tick(1);
		infrared_frame_valid = 1'h0;
		check(infrared_event, 1'h1, "ir set wins");
		tick(1);
		smi_status_two_read = 1'h0;
		check(infrared_event, 1'h0, "ir read clear");
		// group interrupt into the wake logic
		smi_to_wake_clear = 1'h1;
		tick(1);
		smi_to_wake_clear = 1'h0;
		tick(1);
		check(smi_to_wake_status, 1'h0, "s2w clear");
		smi_enable_two = 8'h20;
		periph_event = 6'h01;
		smi_to_wake_enable = 1'h1;
		fixed_wake_enable = 5'h00;
		tick(2);
		check({smi_to_wake_status, wake_summary_status, wake_wire}, 3'h7,
			"s2w wake");
		wrap_up();
	end
endmodule
